/* File: hdl/io_cycle_period_generator.sv */
// Behaviour
// RL1 - Counter steps only on unfrozen late phase
// RL2 - Three flip-flops decode into five periods
// RL3 - Fixed family: every period 325 ns (code: 81 CLK cycles, 324 ns)
// RL4 - Variable family: middle 280, ends 175/280 (code: short ends 43 CLK cycles, 172 ns)
// RL5 - Cycle starts first period, ends last
// RL6 - Only acknowledge during the last period
// RL7 - First period's fall ends instruction freeze
// RL8 - Last period's fall ends acknowledge freeze
// RL9 - Variable family middle periods always long
// RL10 - Idle after last; restart on request
module io_cycle_period_generator
  import io_period_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic VARIABLE_FAMILY,
  input wire logic END_PERIODS_LONG,
  input wire logic IO_INSTR_REQUEST,
  input wire logic INTR_ACK_REQUEST,
  input wire logic IO_CMD_REQUEST,
  output logic IO_PERIOD_FIRST,
  output logic IO_PERIOD_SECOND,
  output logic IO_PERIOD_THIRD,
  output logic IO_PERIOD_FOURTH,
  output logic IO_PERIOD_LAST,
  output logic IO_INSTRUCTION_CYCLE,
  output logic IO_INSTR_FREEZE_REQUEST,
  output logic INTR_ACKNOWLEDGE,
  output logic IO_COMMAND,
  output logic FREEZE
);
  late_phase_if ph ();
  logic io_count_bit_a;
  logic io_count_bit_b;
  logic io_count_bit_c;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic instr_pend_q;
  logic ack_pend_q;
  logic fam_q;
  logic fam_s_q;
  logic endlong_s_q;
  logic endlong_q;
  logic [2:0] req_s_q;
  logic [2:0] req_q;
  logic late_phase_unfrozen;

  // Straps and requests may come from other logic; synchronise anyway
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      fam_s_q <= 1'b0;
      fam_q <= 1'b0;
      endlong_s_q <= 1'b0;
      endlong_q <= 1'b0;
      req_s_q <= 3'h0;
      req_q <= 3'h0;
    end
    else
    begin
      fam_s_q <= VARIABLE_FAMILY;
      fam_q <= fam_s_q;
      endlong_s_q <= END_PERIODS_LONG;
      endlong_q <= endlong_s_q;
      req_s_q <= {IO_CMD_REQUEST, INTR_ACK_REQUEST, IO_INSTR_REQUEST};
      req_q <= req_s_q;
    end
  end

  // Middle periods forced long; ends follow the strap
  assign ph.long_cycle = (cnt_q == CNT_SECOND) || (cnt_q == CNT_THIRD) // [RL4] [RL9]
                        || (cnt_q == CNT_FOURTH) || endlong_q; // [RL3] [RL4]

  late_phase_gen u_phase (
    .clk(CLK),
    .reset_n(RESET_N),
    .variable_family(fam_q),
    .ph(ph)
  );

  assign late_phase_unfrozen = ph.tick;
  assign io_count_bit_a = cnt_q[0];
  assign io_count_bit_b = cnt_q[1];
  assign io_count_bit_c = cnt_q[2];

  // Pending requests latch; set wins over the clear at cycle start
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      instr_pend_q <= 1'b0;
      ack_pend_q <= 1'b0;
    end
    else
    begin
      instr_pend_q <= req_q[0] | (instr_pend_q & ~(late_phase_unfrozen && cnt_q == CNT_IDLE));
      ack_pend_q <= req_q[1] | (ack_pend_q & ~(late_phase_unfrozen && cnt_q == CNT_IDLE));
    end
  end

  // Johnson-style sequence: one bit changes per step
  always_comb
  begin
    case (cnt_q)
      CNT_IDLE: cnt_d = (instr_pend_q || ack_pend_q) ? CNT_FIRST : CNT_IDLE; // [RL10] [RL5]
      CNT_FIRST: cnt_d = CNT_SECOND; // [RL2]
      CNT_SECOND: cnt_d = CNT_THIRD;
      CNT_THIRD: cnt_d = CNT_FOURTH;
      CNT_FOURTH: cnt_d = CNT_LAST;
      CNT_LAST: cnt_d = CNT_IDLE; // [RL5] [RL10]
      default: cnt_d = CNT_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      cnt_q <= CNT_IDLE;
    else if (late_phase_unfrozen) // [RL1]
      cnt_q <= cnt_d;
  end

  logic kind_instr_q;
  logic kind_ack_q;
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      kind_instr_q <= 1'b0;
      kind_ack_q <= 1'b0;
    end
    else if (late_phase_unfrozen && cnt_q == CNT_IDLE && cnt_d == CNT_FIRST)
    begin
      kind_instr_q <= instr_pend_q;
      kind_ack_q <= ack_pend_q;
    end
  end

  // Period decode from the three count bits
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      IO_PERIOD_FIRST <= 1'b0;
      IO_PERIOD_SECOND <= 1'b0;
      IO_PERIOD_THIRD <= 1'b0;
      IO_PERIOD_FOURTH <= 1'b0;
      IO_PERIOD_LAST <= 1'b0;
      IO_INSTRUCTION_CYCLE <= 1'b0;
      IO_COMMAND <= 1'b0;
      INTR_ACKNOWLEDGE <= 1'b0;
    end
    else
    begin
      IO_PERIOD_FIRST <= !io_count_bit_c && !io_count_bit_b && io_count_bit_a; // [RL2]
      IO_PERIOD_SECOND <= !io_count_bit_c && io_count_bit_b; // [RL2]
      IO_PERIOD_THIRD <= io_count_bit_c && io_count_bit_a; // [RL2]
      IO_PERIOD_FOURTH <= io_count_bit_c && io_count_bit_b && !io_count_bit_a; // [RL2]
      IO_PERIOD_LAST <= io_count_bit_c && !io_count_bit_b; // [RL2]
      IO_INSTRUCTION_CYCLE <= kind_instr_q && (cnt_q != CNT_IDLE);
      // General commands suppressed in the last period
      IO_COMMAND <= req_q[2] && kind_instr_q && (cnt_q != CNT_IDLE)
                    && (cnt_q != CNT_LAST); // [RL6]
      INTR_ACKNOWLEDGE <= kind_ack_q && (cnt_q != CNT_IDLE); // [RL8]
    end
  end

  // Freezes: instruction freeze ends as the first period falls,
  // acknowledge freeze as the last period falls
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      IO_INSTR_FREEZE_REQUEST <= 1'b0;
    else
      IO_INSTR_FREEZE_REQUEST <= instr_pend_q
        || (kind_instr_q && (cnt_q == CNT_FIRST)); // [RL7]
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      FREEZE <= 1'b0;
    else
      FREEZE <= instr_pend_q || ack_pend_q || (kind_instr_q && cnt_q == CNT_FIRST) // [RL7]
        || (kind_ack_q && cnt_q != CNT_IDLE); // [RL8]
  end

  property p_step_only_on_tick;
    @(posedge CLK) disable iff (!RESET_N)
      !late_phase_unfrozen |=> $stable(cnt_q);
  endproperty
  a_step_only_on_tick: assert property (p_step_only_on_tick) // [RL1]
    else $error("count moved without late phase");

  property p_one_period;
    @(posedge CLK) disable iff (!RESET_N)
      $onehot0({IO_PERIOD_FIRST, IO_PERIOD_SECOND, IO_PERIOD_THIRD,
                IO_PERIOD_FOURTH, IO_PERIOD_LAST});
  endproperty
  a_one_period: assert property (p_one_period) // [RL2]
    else $error("more than one period active");

  sequence s_first_start;
    late_phase_unfrozen && cnt_q == CNT_IDLE && cnt_d == CNT_FIRST;
  endsequence
  property p_start_first;
    @(posedge CLK) disable iff (!RESET_N)
      s_first_start |=> (cnt_q == CNT_FIRST) ##1 IO_PERIOD_FIRST;
  endproperty
  a_start_first: assert property (p_start_first) // [RL5]
    else $error("cycle did not begin with first period");

  property p_last_to_idle;
    @(posedge CLK) disable iff (!RESET_N)
      (late_phase_unfrozen && cnt_q == CNT_LAST) |=> cnt_q == CNT_IDLE;
  endproperty
  a_last_to_idle: assert property (p_last_to_idle) // [RL10]
    else $error("counter did not idle after last period");

  property p_no_cmd_last;
    @(posedge CLK) disable iff (!RESET_N)
      IO_PERIOD_LAST |-> !IO_COMMAND;
  endproperty
  a_no_cmd_last: assert property (p_no_cmd_last) // [RL6]
    else $error("command during last period");

  property p_ack_ends;
    @(posedge CLK) disable iff (!RESET_N)
      $past(INTR_ACKNOWLEDGE) && $fell(IO_PERIOD_LAST) |-> !INTR_ACKNOWLEDGE;
  endproperty
  a_ack_ends: assert property (p_ack_ends) // [RL8]
    else $error("acknowledge outlived last period");

  property p_freeze_ends;
    @(posedge CLK) disable iff (!RESET_N)
      $fell(IO_PERIOD_FIRST) && !$past(instr_pend_q) |-> !IO_INSTR_FREEZE_REQUEST;
  endproperty
  a_freeze_ends: assert property (p_freeze_ends) // [RL7]
    else $error("instruction freeze outlived first period");

  // Cycles since the last step; measures periods independently of the divider
  logic [PHASE_W-1:0] per_len_q;
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      per_len_q <= PHASE_RESET;
    else if (late_phase_unfrozen)
      per_len_q <= PHASE_RESET;
    else
      per_len_q <= per_len_q + PHASE_W'(1);
  end

  property p_middle_long;
    @(posedge CLK) disable iff (!RESET_N)
      (late_phase_unfrozen && fam_q && ((cnt_q == CNT_SECOND) || (cnt_q == CNT_THIRD)
        || (cnt_q == CNT_FOURTH))) |-> (per_len_q == PHASE_W'(PHASE_CYC_LONG - 1));
  endproperty
  a_middle_long: assert property (p_middle_long) // [RL9]
    else $error("middle period not long");
endmodule // io_cycle_period_generator

/* File: hdl/io_period_pkg.sv */
package io_period_pkg;
  // Clock period in picoseconds (250 MHz)
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PERIOD_FIXED_NS = 325;
  localparam int PERIOD_LONG_NS = 280;
  localparam int PERIOD_SHORT_NS = 175;
  // Period lengths in CLK cycles (one late-phase enable per period)
  localparam int PHASE_CYC_FIXED = (PERIOD_FIXED_NS * 1000) / CLK_PERIOD_PS;
  localparam int PHASE_CYC_LONG = (PERIOD_LONG_NS * 1000) / CLK_PERIOD_PS;
  localparam int PHASE_CYC_SHORT = (PERIOD_SHORT_NS * 1000) / CLK_PERIOD_PS;
  localparam int PHASE_W = 8;
  localparam logic [2:0] CNT_IDLE = 3'h0;
  localparam logic [2:0] CNT_FIRST = 3'h1;
  localparam logic [2:0] CNT_SECOND = 3'h3;
  localparam logic [2:0] CNT_THIRD = 3'h7;
  localparam logic [2:0] CNT_FOURTH = 3'h6;
  localparam logic [2:0] CNT_LAST = 3'h4;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 8'h00;

  typedef enum logic [1:0] {
    FAMILY_FIXED = 2'h0,
    FAMILY_VARIABLE = 2'h1
  } family_t;
endpackage : io_period_pkg

/* File: hdl/late_phase_gen.sv */
// Free-running late-phase enable; never gated by processor freezes.
module late_phase_gen
  import io_period_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic variable_family,
  late_phase_if.gen ph
);
  logic [PHASE_W-1:0] cnt_q;
  logic [PHASE_W-1:0] limit;

  always_comb
  begin
    if (!variable_family)
      limit = PHASE_W'(PHASE_CYC_FIXED - 1); // [RL3]
    else if (ph.long_cycle)
      limit = PHASE_W'(PHASE_CYC_LONG - 1); // [RL4]
    else
      limit = PHASE_W'(PHASE_CYC_SHORT - 1); // [RL4]
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cnt_q <= PHASE_RESET;
    else if (cnt_q >= limit)
      cnt_q <= PHASE_RESET;
    else
      cnt_q <= cnt_q + PHASE_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ph.tick <= 1'b0;
    else
      ph.tick <= (cnt_q >= limit);
  end
endmodule // late_phase_gen

/* File: hdl/late_phase_if.sv */
interface late_phase_if;
  logic tick;
  logic long_cycle;
  modport gen (output tick, input long_cycle);
  modport use_side (input tick, output long_cycle);
endinterface : late_phase_if

/* File: test/io_card_model.sv */
// Backplane card: tallies clock cycles with command high and flags any seen in the last period
module io_card_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic period_last,
  input wire logic command,
  output logic [15:0] cmd_count_q,
  output logic bad_cmd_q
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cmd_count_q <= 16'h0000;
    else if (command)
      cmd_count_q <= cmd_count_q + 16'h0001;
  end

  // Sticky, so a single stray cycle is never lost
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      bad_cmd_q <= 1'b0;
    else if (period_last && command)
      bad_cmd_q <= 1'b1;
  end
endmodule // io_card_model

/* File: test/io_cycle_period_generator_tb.sv */
module io_cycle_period_generator_tb;
  import io_period_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic VARIABLE_FAMILY = 1'b0;
  logic END_PERIODS_LONG = 1'b0;
  logic IO_INSTR_REQUEST = 1'b0;
  logic INTR_ACK_REQUEST = 1'b0;
  logic IO_CMD_REQUEST = 1'b0;
  logic p1, p2, p3, p4, p5, instr_cyc, frz_req, ack, cmd, frz, bad_cmd;
  logic [15:0] cmd_count;
  int fail_count = 0;
  int checks = 0;

  io_cycle_period_generator io_cycle_period_generator_i (.CLK(CLK), .RESET_N(RESET_N),
    .VARIABLE_FAMILY(VARIABLE_FAMILY), .END_PERIODS_LONG(END_PERIODS_LONG),
    .IO_INSTR_REQUEST(IO_INSTR_REQUEST), .INTR_ACK_REQUEST(INTR_ACK_REQUEST),
    .IO_CMD_REQUEST(IO_CMD_REQUEST), .IO_PERIOD_FIRST(p1), .IO_PERIOD_SECOND(p2),
    .IO_PERIOD_THIRD(p3), .IO_PERIOD_FOURTH(p4), .IO_PERIOD_LAST(p5),
    .IO_INSTRUCTION_CYCLE(instr_cyc), .IO_INSTR_FREEZE_REQUEST(frz_req),
    .INTR_ACKNOWLEDGE(ack), .IO_COMMAND(cmd), .FREEZE(frz));

  io_card_model io_card_model_i (.clk(CLK), .reset_n(RESET_N), .period_last(p5),
    .command(cmd), .cmd_count_q(cmd_count), .bad_cmd_q(bad_cmd));

  initial
  begin
    forever #2 CLK = ~CLK;
  end

  function automatic logic [4:0] per();
    return {p5, p4, p3, p2, p1};
  endfunction

  task automatic summarize();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_int(input string name, input int exp, input int got);
    checks++;
    if (got != exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic check_vec(input string name, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic request(input bit is_ack);
    @(posedge CLK);
    IO_INSTR_REQUEST <= !is_ack;
    INTR_ACK_REQUEST <= is_ack;
    @(posedge CLK);
    IO_INSTR_REQUEST <= 1'b0;
    INTR_ACK_REQUEST <= 1'b0;
  endtask

  // Measures each period on falling edges, away from the design's updates
  task automatic run_cycle(input int e_end, input int e_mid, input logic is_ack);
    int n;
    n = 0;
    @(negedge CLK);
    while (per() !== 5'h01 && n < 400)
    begin
      @(negedge CLK);
      n++;
    end
    check_bit("instr_freeze_in_first", !is_ack, frz_req);
    for (int k = 0; k < 5; k++)
    begin
      check_vec("period_order", 5'h01 << k, per());
      check_bit("ack_level", is_ack, ack);
      check_bit("instr_cycle", !is_ack, instr_cyc);
      check_bit("freeze", (k == 0) || is_ack, frz);
      n = 0;
      while (per() === (5'h01 << k) && n < 200)
      begin
        @(negedge CLK);
        n++;
      end
      check_int("period_len", (k == 0 || k == 4) ? e_end : e_mid, n);
      if (k == 0)
        check_bit("instr_freeze_after_first", 1'b0, frz_req);
    end
    check_vec("after_last", 5'h00, per());
    check_bit("ack_after_last", 1'b0, ack);
    check_bit("freeze_after_last", 1'b0, frz);
    check_bit("cmd_in_last", 1'b0, bad_cmd);
  endtask

  task automatic t_fixed_instr();
    VARIABLE_FAMILY <= 1'b0;
    IO_CMD_REQUEST <= 1'b1;
    repeat (4) @(posedge CLK);
    request(1'b0);
    run_cycle(PHASE_CYC_FIXED, PHASE_CYC_FIXED, 1'b0);
    check_bit("cmd_seen", 1'b1, cmd_count != 16'h0000);
  endtask

  task automatic t_var_short_ack();
    @(posedge CLK);
    VARIABLE_FAMILY <= 1'b1;
    END_PERIODS_LONG <= 1'b0;
    repeat (4) @(posedge CLK);
    request(1'b1);
    run_cycle(PHASE_CYC_SHORT, PHASE_CYC_LONG, 1'b1);
  endtask

  task automatic t_var_long_idle();
    logic [15:0] cnt0;
    @(posedge CLK);
    END_PERIODS_LONG <= 1'b1;
    IO_CMD_REQUEST <= 1'b0;
    repeat (4) @(posedge CLK);
    cnt0 = cmd_count;
    request(1'b0);
    run_cycle(PHASE_CYC_LONG, PHASE_CYC_LONG, 1'b0);
    check_bit("cmd_without_request", 1'b1, cmd_count === cnt0);
    repeat (300) @(negedge CLK);
    check_vec("idle_no_request", 5'h00, per());
  endtask

  initial
  begin
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_fixed_instr();
    t_var_short_ack();
    t_var_long_idle();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    summarize();
  end
endmodule // io_cycle_period_generator_tb
